// [analog_process_data_mapper.sv]
// Function
// - Input fields hold 2, 4 or 8 words, one channel value per word, set by the module size.
// - Output fields hold 2, 4 or 8 words and carry controller values toward the nodes.
// - One segment uses field 1 only; two segments keep separate line 1 and line 2 fields.
// - Filter 1+2 with first address 4 puts channels 1 and 2 of nodes 4 to 7 into an 8-word field.
// - An 8-word input field goes to the controller as one 16-byte packet per cycle.
// - Filter 1+2 gives each node four bytes, channel 1 then channel 2, in rising address order.
// - Filter 1 gives each node two bytes of channel 1, so 16 bytes span eight nodes.
// - A-addressed nodes fill channels 1 and 2, B-addressed nodes channels 3 and 4.
// - Each segment has a collective error bit telling whether that segment has an error.
// - A node delivers at most four channels of 16 bits, two bytes each.
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`include "mapper_cfg.svh"

module analog_process_data_mapper (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire mapper_pkg::node_in_s node_in_i,
  input wire mapper_pkg::node_req_s node_req_i,
  output mapper_pkg::node_rsp_s node_rsp_o,
  input wire logic plc_cycle_i,
  input wire mapper_pkg::field_t [1:0] ao_field_i,
  output mapper_pkg::field_t [1:0] ai_field_o,
  input wire logic [1:0][7:0] seg_fault_i,
  output logic [1:0] seg_err_o,
  output logic irq_o
);
  import mapper_pkg::*;

  cfg_s cfg;
  logic [`IRQ_W-1:0] irq_stat;
  logic [`IRQ_W-1:0] irq_mask;
  field_t [1:0] shadow;
  field_t [1:0] ao_img;
  map_s in_map;
  map_s req_map;
  logic in_ok;
  logic req_ok;
  logic bus_req;
  logic taken;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;
  logic [1:0] next_err;
  logic [`IRQ_W-1:0] events;
  logic [31:0] wmask;
  logic [31:0] next_ctrl;

  function automatic map_s map_slot(cfg_s c, logic ab, logic [4:0] addr,
                                    logic [1:0] chan);
    logic [4:0] offs;
    logic [1:0] ch;
    logic [6:0] lin;
    logic ok;
    logic [3:0] words;
    map_s r;
    offs = addr - c.first;
    ch = ab ? {1'b1, chan[0]} : chan;
    case (c.filt)
      FILT_ALL4: begin
        lin = {offs, ch};
        ok = 1'b1;
      end
      FILT_CH12: begin
        lin = {1'b0, offs, ch[0]};
        ok = ~ch[1];
      end
      default: begin
        lin = {2'h0, offs};
        ok = (ch == 2'h0);
      end
    endcase
    case (c.size)
      FSZ_8W: words = 4'h8;
      FSZ_4W: words = 4'h4;
      default: words = 4'h2;
    endcase
    // lowest address first, then consecutive
    r.hit = ok && (addr >= c.first) && (!ab || !chan[1]) &&
            (lin < {3'h0, words});
    r.idx = lin[2:0];
    return r;
  endfunction : map_slot

  assign in_map = map_slot(cfg, node_in_i.ab, node_in_i.addr, node_in_i.chan);
  assign req_map = map_slot(cfg, node_req_i.ab, node_req_i.addr, node_req_i.chan);
  // line 2 only exists in two-segment mode
  assign in_ok = node_in_i.valid && in_map.hit &&
                 (cfg.two_seg || !node_in_i.seg);
  assign req_ok = node_req_i.valid && req_map.hit &&
                  (cfg.two_seg || !node_req_i.seg);

  assign bus_req = avs_read_i | avs_write_i;
  assign taken = bus_req & ~avs_waitrequest_o;
  assign wr_ctrl = taken && avs_write_i && (avs_address_i == `REG_CTRL);
  assign wr_stat = taken && avs_write_i && (avs_address_i == `REG_IRQ_STAT);
  assign wr_mask = taken && avs_write_i && (avs_address_i == `REG_IRQ_MASK);
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign next_ctrl = (avs_writedata_i & wmask) |
                     ({22'h0, cfg} & ~wmask);

  // collective error per segment
  assign next_err[0] = |seg_fault_i[0];
  assign next_err[1] = cfg.two_seg && (|seg_fault_i[1]);

  assign events[`IRQ_SEG1_ERR] = next_err[0] & ~seg_err_o[0];
  assign events[`IRQ_SEG2_ERR] = next_err[1] & ~seg_err_o[1];
  assign events[`IRQ_CYCLE] = plc_cycle_i;
  assign events[`IRQ_DROP] = node_in_i.valid & ~in_ok;

  // one wait cycle, then the request is taken
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (clk_en_i) begin
      avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      avs_readdata_o <= 32'h0;
    end else if (clk_en_i && bus_req && avs_waitrequest_o) begin
      case (avs_address_i)
        `REG_CTRL: avs_readdata_o <= {22'h0, cfg};
        `REG_STAT: avs_readdata_o <= {30'h0, seg_err_o};
        `REG_IRQ_STAT: avs_readdata_o <= {28'h0, irq_stat};
        `REG_IRQ_MASK: avs_readdata_o <= {28'h0, irq_mask};
        default: avs_readdata_o <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg <= cfg_s'(`CTRL_RST);
    end else if (clk_en_i && wr_ctrl) begin
      cfg <= cfg_s'(next_ctrl[`CTRL_W-1:0]);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_mask <= `IRQ_MASK_RST;
    end else if (clk_en_i && wr_mask && avs_byteenable_i[0]) begin
      irq_mask <= avs_writedata_i[`IRQ_W-1:0];
    end
  end

  // write one clears, a new event wins
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_stat <= '0;
    end else if (clk_en_i) begin
      if (wr_stat && avs_byteenable_i[0]) begin
        irq_stat <= (irq_stat & ~avs_writedata_i[`IRQ_W-1:0]) | events;
      end else begin
        irq_stat <= irq_stat | events;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      seg_err_o <= 2'h0;
    end else if (clk_en_i) begin
      seg_err_o <= next_err;
    end
  end

  // node side collection; a new mapping starts from an empty field
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      shadow <= '0;
    end else if (clk_en_i) begin
      if (wr_ctrl) begin
        shadow <= '0;
      end else if (in_ok) begin
        shadow[node_in_i.seg][in_map.idx] <= node_in_i.value;
      end
    end
  end

  // whole packet handed over at the controller cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ai_field_o <= '0;
    end else if (clk_en_i && plc_cycle_i) begin
      ai_field_o <= shadow;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ao_img <= '0;
    end else if (clk_en_i) begin
      if (wr_ctrl) begin
        ao_img <= '0;
      end else if (plc_cycle_i) begin
        ao_img <= ao_field_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      node_rsp_o <= '0;
    end else if (clk_en_i) begin
      node_rsp_o.valid <= req_ok;
      // uncovered requests get nothing
      node_rsp_o.value <= req_ok ? ao_img[node_req_i.seg][req_map.idx] : 16'h0;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  two_ch_map_a: assert property (
    clk_en_i && node_in_i.valid && !node_in_i.seg && !node_in_i.ab &&
    cfg.filt == FILT_CH12 && cfg.size == FSZ_8W && cfg.first == 5'h4 &&
    node_in_i.addr == 5'h7 && node_in_i.chan == 2'h1 && !wr_ctrl
    |=> shadow[0][7] == $past(node_in_i.value))
    else $error("node 7 channel 2 not in last word");

  ch12_order_a: assert property (
    clk_en_i && in_ok && !node_in_i.ab && cfg.filt == FILT_CH12 && !wr_ctrl
    |-> in_map.idx == 3'((node_in_i.addr - cfg.first) * 2 + node_in_i.chan))
    else $error("two channel slot order wrong");

  one_ch_map_a: assert property (
    clk_en_i && node_in_i.valid && !node_in_i.seg && !node_in_i.ab &&
    cfg.filt == FILT_CH1 && cfg.size == FSZ_8W && cfg.first == 5'h4 &&
    node_in_i.addr == 5'hb && node_in_i.chan == 2'h0 && !wr_ctrl
    |=> shadow[0][7] == $past(node_in_i.value))
    else $error("node 11 channel 1 not in last word");

  ab_map_a: assert property (
    clk_en_i && node_in_i.valid && !node_in_i.seg && node_in_i.ab &&
    cfg.filt == FILT_ALL4 && cfg.first == node_in_i.addr &&
    cfg.size != FSZ_2W && node_in_i.chan == 2'h0 && !wr_ctrl
    |=> shadow[0][2] == $past(node_in_i.value))
    else $error("b node not in channel 3");

  size_limit_a: assert property (
    cfg.size == FSZ_2W |-> shadow[0][7:2] == '0 && shadow[1][7:2] == '0)
    else $error("2 word field has data beyond word 1");

  single_seg_a: assert property (
    !cfg.two_seg |-> shadow[1] == '0 && !seg_err_o[1] || $past(cfg.two_seg))
    else $error("line 2 used in single segment mode");

  clear_cfg_a: assert property (
    clk_en_i && wr_ctrl |=> shadow == '0 && ao_img == '0)
    else $error("field not cleared on new mapping");

  packet_copy_a: assert property (
    clk_en_i && plc_cycle_i |=> ai_field_o == $past(shadow))
    else $error("input packet not taken whole");

  out_hit_a: assert property (
    clk_en_i && req_ok |=> node_rsp_o.valid &&
    node_rsp_o.value == $past(ao_img[node_req_i.seg][req_map.idx]))
    else $error("output word not delivered");

  out_miss_a: assert property (
    clk_en_i && !req_ok |=> !node_rsp_o.valid && node_rsp_o.value == 16'h0)
    else $error("uncovered output not ignored");

  seg_err_a: assert property (
    clk_en_i && (|seg_fault_i[0]) |=> seg_err_o[0])
    else $error("segment 1 error not flagged");

  word_whole_a: assert property (
    clk_en_i && !plc_cycle_i |=> $stable(ai_field_o))
    else $error("input field changed outside cycle");

  wait_one_a: assert property (
    clk_en_i && bus_req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");

  irq_high_a: assert property (
    clk_en_i && (|(irq_stat & irq_mask)) |=> irq_o)
    else $error("interrupt not raised");

  irq_low_a: assert property (
    clk_en_i && !(|(irq_stat & irq_mask)) |=> !irq_o)
    else $error("interrupt not dropped");

  event_set_a: assert property (
    clk_en_i && (|events) |=> (irq_stat & $past(events)) == $past(events))
    else $error("event lost in status");

  write_clear_a: assert property (
    clk_en_i && wr_stat && avs_byteenable_i[0] && !(|events)
    |=> (irq_stat & $past(avs_writedata_i[`IRQ_W-1:0])) == '0)
    else $error("status bit not cleared");

  line2_quiet_a: assert property (
    clk_en_i && !cfg.two_seg |=> !seg_err_o[1])
    else $error("segment 2 error in single segment mode");

  seg1_clear_a: assert property (
    clk_en_i && !(|seg_fault_i[0]) |=> !seg_err_o[0])
    else $error("segment 1 error without fault");

  seg2_err_a: assert property (
    clk_en_i && cfg.two_seg && (|seg_fault_i[1]) |=> seg_err_o[1])
    else $error("segment 2 error not flagged");

  drop_flag_a: assert property (
    clk_en_i && node_in_i.valid && !in_ok |=> irq_stat[`IRQ_DROP])
    else $error("dropped input not flagged");

  wait_back_a: assert property (
    clk_en_i && taken |=> avs_waitrequest_o)
    else $error("wait not raised after transfer");

  mask_read_a: assert property (
    clk_en_i && avs_read_i && avs_waitrequest_o && avs_address_i == `REG_IRQ_MASK
    |=> avs_readdata_o == {28'h0, $past(irq_mask)})
    else $error("mask read wrong");

  ctrl_write_a: assert property (
    clk_en_i && wr_ctrl && avs_byteenable_i == 4'hf
    |=> cfg == $past(avs_writedata_i[`CTRL_W-1:0]))
    else $error("control write lost");

  freeze_state_a: assert property (
    !clk_en_i |=> $stable(shadow) && $stable(ai_field_o) && $stable(cfg) &&
    $stable(irq_stat))
    else $error("state moved while disabled");

  miss_keep_a: assert property (
    clk_en_i && !in_ok && !wr_ctrl |=> $stable(shadow))
    else $error("field changed without mapped input");

  out_latch_a: assert property (
    clk_en_i && plc_cycle_i && !wr_ctrl |=> ao_img == $past(ao_field_i))
    else $error("output field not latched");

endmodule : analog_process_data_mapper

// [mapper_cfg.svh]
`ifndef MAPPER_CFG_SVH
`define MAPPER_CFG_SVH

// register byte offsets
`define REG_CTRL 4'h0
`define REG_STAT 4'h4
`define REG_IRQ_STAT 4'h8
`define REG_IRQ_MASK 4'hc

// ctrl field positions and widths
`define CTRL_TWO_SEG_POS 0
`define CTRL_FILT_POS 1
`define CTRL_SIZE_POS 3
`define CTRL_FIRST_POS 5
`define CTRL_W 10

// reset values
`define CTRL_RST 10'h000
`define IRQ_MASK_RST 4'h0

// interrupt bit positions
`define IRQ_SEG1_ERR 0
`define IRQ_SEG2_ERR 1
`define IRQ_CYCLE 2
`define IRQ_DROP 3
`define IRQ_W 4

`endif

// [mapper_pkg.sv]
package mapper_pkg;

  typedef enum logic [1:0] {
    FILT_CH1 = 2'h0,
    FILT_CH12 = 2'h1,
    FILT_ALL4 = 2'h3
  } filt_e;

  typedef enum logic [1:0] {
    FSZ_2W = 2'h0,
    FSZ_4W = 2'h1,
    FSZ_8W = 2'h3
  } fsize_e;

  typedef logic [15:0] word_t;
  typedef word_t [7:0] field_t;

  // matches the ctrl register layout, lsb is two_seg
  typedef struct packed {
    logic [4:0] first;
    fsize_e size;
    filt_e filt;
    logic two_seg;
  } cfg_s;

  typedef struct packed {
    logic valid;
    logic seg;
    logic ab;
    logic [4:0] addr;
    logic [1:0] chan;
    word_t value;
  } node_in_s;

  typedef struct packed {
    logic valid;
    logic seg;
    logic ab;
    logic [4:0] addr;
    logic [1:0] chan;
  } node_req_s;

  typedef struct packed {
    logic valid;
    word_t value;
  } node_rsp_s;

  typedef struct packed {
    logic hit;
    logic [2:0] idx;
  } map_s;

endpackage : mapper_pkg

// [plc_image_model.sv]
`timescale 1ns/1ps
module plc_image_model (
  input wire logic clk_sys_i,
  input wire logic go_i,
  input wire mapper_pkg::field_t [1:0] ai_field_i,
  output logic plc_cycle_o,
  output mapper_pkg::field_t [1:0] ao_field_o,
  output mapper_pkg::field_t [1:0] image_o
);
  import mapper_pkg::*;
  logic taken;
  // fixed output image, word w of line l is c000 + 8l + w
  always_comb begin
    for (int l = 0; l < 2; l++) begin
      for (int w = 0; w < 8; w++) begin
        ao_field_o[l][w] = 16'hc000 + 16'(l * 8 + w);
      end
    end
  end
  // one cycle pulse, whole packet captured once it has settled
  always @(posedge clk_sys_i) begin
    plc_cycle_o <= go_i;
    taken <= plc_cycle_o;
    if (taken) begin
      image_o <= ai_field_i;
    end
  end
endmodule : plc_image_model

// [analog_process_data_mapper_tb.sv]
`timescale 1ns/1ps
`include "mapper_cfg.svh"
module analog_process_data_mapper_tb;
  import mapper_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic wreq, irq, plc_cycle;
  logic go = 1'b0;
  logic en = 1'b1;
  node_in_s node_in = '0;
  node_req_s node_req = '0;
  node_rsp_s node_rsp;
  field_t [1:0] ao, ai, img;
  field_t e;
  logic [1:0][7:0] seg_fault = '0;
  logic [1:0] seg_err;
  int failures = 0;
  int compares = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  analog_process_data_mapper dut_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_en_i(en),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .node_in_i(node_in), .node_req_i(node_req), .node_rsp_o(node_rsp), .plc_cycle_i(plc_cycle),
    .ao_field_i(ao), .ai_field_o(ai), .seg_fault_i(seg_fault), .seg_err_o(seg_err), .irq_o(irq));
  plc_image_model pm_u (.clk_sys_i(clk_sys_i), .go_i(go), .ai_field_i(ai),
    .plc_cycle_o(plc_cycle), .ao_field_o(ao), .image_o(img));
  task end_of_test;
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  function logic [15:0] v(input int b, input int a, input int c);
    return {7'h2d, 1'(b), 5'(a), 1'b0, 2'(c)};
  endfunction : v
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do begin
      @(posedge clk_sys_i);
    end while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task put(input int s, input int b, input int a, input int c);
    @(posedge clk_sys_i);
    node_in <= {1'b1, 1'(s), 1'(b), 5'(a), 2'(c), v(b, a, c)};
  endtask : put
  task cyc;
    @(posedge clk_sys_i);
    node_in <= '0;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask : cyc
  task chkf(input int l);
    for (int w = 0; w < 8; w++) check("ai word", {16'h0, img[l][w]}, {16'h0, e[w]});
  endtask : chkf
  task t_regs;
    bus(1'b0, `REG_CTRL, '0);
    check("ctrl reset", q, 32'h0);
    bus(1'b0, `REG_IRQ_MASK, '0);
    check("mask reset", q, 32'h0);
    bus(1'b1, 4'h2, 32'hffff_ffff);
    bus(1'b0, 4'h2, '0);
    check("unmapped", q, 32'h0);
  endtask : t_regs
  task t_ch12;
    bus(1'b1, `REG_CTRL, 32'h9a);
    for (int a = 4; a < 8; a++) for (int c = 0; c < 2; c++) put(0, 0, a, c);
    cyc();
    for (int w = 0; w < 8; w++) e[w] = v(0, 4 + w / 2, w % 2);
    chkf(0);
    @(posedge clk_sys_i);
    node_req <= {1'b1, 1'b0, 1'b0, 5'h5, 2'h1};
    @(posedge clk_sys_i);
    node_req <= {1'b1, 1'b0, 1'b0, 5'h9, 2'h0};
    @(posedge clk_sys_i);
    node_req <= '0;
    check("rsp", {15'h0, node_rsp}, {15'h0, 1'b1, 16'hc003});
    @(posedge clk_sys_i);
    check("rsp unmapped", {15'h0, node_rsp}, 32'h0);
  endtask : t_ch12
  task t_ch1;
    bus(1'b1, `REG_CTRL, 32'h98);
    for (int a = 4; a < 12; a++) put(0, 0, a, 0);
    cyc();
    for (int w = 0; w < 8; w++) e[w] = v(0, 4 + w, 0);
    chkf(0);
  endtask : t_ch1
  task t_all4;
    bus(1'b1, `REG_CTRL, 32'h8e);
    for (int i = 0; i < 4; i++) put(0, i / 2, 4, i % 2);
    put(0, 0, 5, 0);
    put(0, 0, 3, 0);
    cyc();
    e = '0;
    for (int i = 0; i < 4; i++) e[i] = v(i / 2, 4, i % 2);
    chkf(0);
    bus(1'b0, `REG_IRQ_STAT, '0);
    check("drop and cycle flags", q & 32'hc, 32'hc);
    bus(1'b1, `REG_IRQ_MASK, 32'h8);
    repeat (3) @(posedge clk_sys_i);
    check("irq on", {31'h0, irq}, 32'h1);
    bus(1'b1, `REG_IRQ_STAT, 32'h8);
    repeat (3) @(posedge clk_sys_i);
    check("irq off", {31'h0, irq}, 32'h0);
  endtask : t_all4
  task t_seg;
    seg_fault <= {8'h01, 8'h10};
    repeat (4) @(posedge clk_sys_i);
    check("seg err one", {30'h0, seg_err}, 32'h1);
    bus(1'b1, `REG_CTRL, 32'h8f);
    repeat (4) @(posedge clk_sys_i);
    check("seg err two", {30'h0, seg_err}, 32'h3);
    bus(1'b0, `REG_STAT, '0);
    check("stat", q, 32'h3);
    put(1, 0, 4, 0);
    cyc();
    check("line2", {16'h0, img[1][0]}, {16'h0, v(0, 4, 0)});
    check("line1", {16'h0, img[0][0]}, 32'h0);
  endtask : t_seg
  task t_small;
    en <= 1'b0;
    put(0, 0, 4, 0);
    cyc();
    en <= 1'b1;
    cyc();
    check("frozen", {16'h0, img[0][0]}, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h80);
    for (int a = 4; a < 7; a++) put(0, 0, a, 0);
    cyc();
    e = '0;
    e[0] = v(0, 4, 0);
    e[1] = v(0, 5, 0);
    chkf(0);
    check("irq drop", {31'h0, irq}, 32'h1);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    check("ai reset", {16'h0, ai[0][0]}, 32'h0);
    check("irq reset", {31'h0, irq}, 32'h0);
    bus(1'b0, `REG_CTRL, '0);
    check("ctrl after reset", q, 32'h0);
  endtask : t_small
  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_regs();
    t_ch12();
    t_ch1();
    t_all4();
    t_seg();
    t_small();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    failures++;
    end_of_test();
  end
endmodule : analog_process_data_mapper_tb
